/* File: hw/time_interval_counter.sv */
`timescale 1ns/10ps
module time_interval_counter #(
  parameter int TICK_DIV = tic_pkg::TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic irq_enable_i,
  input wire logic power_down_i,
  output logic irq_o,
  output logic wake_o,
  output logic [15:0] wake_vector_o
);
  import tic_pkg::*;

  localparam int PW = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
  localparam logic [PW-1:0] PRE_LAST = PW'(TICK_DIV - 1);
  localparam logic [PW-1:0] PRE_ONE = PW'(1);
  localparam logic [PW-1:0] PRE_ZERO = PW'(0);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_sync_b;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_sync_b = rst_sync_reg;

  // ****************************************************************
  // register decode
  // ****************************************************************
  logic ctrl_wr;
  logic target_wr;
  logic time_wr_ok;

  assign ctrl_wr = sfr_wr_i && (sfr_addr_i == CTRL_ADDR);
  assign target_wr = sfr_wr_i && (sfr_addr_i == TARGET_ADDR);

  // ****************************************************************
  // control register
  // ****************************************************************
  logic timekeeping_clock_enable_reg;
  logic timekeeping_clock_enable_next;
  logic interval_count_enable_reg;
  logic interval_count_enable_next;
  logic flag_reg;
  logic flag_next;
  logic oneshot_reg;
  logic oneshot_next;
  logic rsvd6_reg;
  logic rsvd6_next;
  base_sel_t base_reg;
  base_sel_t base_next;
  logic timekeeping_clock_enable_off;
  logic timeout;

  // the clear fires only on the falling write, so loads made while
  // timekeeping is off are not wiped by later control writes
  assign timekeeping_clock_enable_off = ctrl_wr && !sfr_wdata_i[TIMEKEEPING_CLOCK_ENABLE_BIT] && timekeeping_clock_enable_reg;
  assign time_wr_ok = sfr_wr_i && !timekeeping_clock_enable_reg;

  always_comb begin
    timekeeping_clock_enable_next = timekeeping_clock_enable_reg;
    interval_count_enable_next = interval_count_enable_reg;
    oneshot_next = oneshot_reg;
    rsvd6_next = rsvd6_reg;
    base_next = base_reg;
    if (ctrl_wr) begin
      timekeeping_clock_enable_next = sfr_wdata_i[TIMEKEEPING_CLOCK_ENABLE_BIT];
      interval_count_enable_next = sfr_wdata_i[INTERVAL_COUNT_ENABLE_BIT];
      oneshot_next = sfr_wdata_i[ONESHOT_BIT];
      rsvd6_next = sfr_wdata_i[RSVD6_BIT];
      base_next = base_sel_t'({sfr_wdata_i[BASE_HI_BIT], sfr_wdata_i[BASE_LO_BIT]});
    end else if (timeout && oneshot_reg) begin
      interval_count_enable_next = 1'b0;
    end
    // hardware set wins over a software clear in the same cycle
    flag_next = timeout || (flag_reg && !(ctrl_wr && !sfr_wdata_i[FLAG_BIT]));
  end

  always_ff @(posedge clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      timekeeping_clock_enable_reg <= 1'b0;
      interval_count_enable_reg <= 1'b0;
      flag_reg <= 1'b0;
      oneshot_reg <= 1'b0;
      rsvd6_reg <= 1'b0;
      base_reg <= BASE_TICK;
    end else begin
      timekeeping_clock_enable_reg <= timekeeping_clock_enable_next;
      interval_count_enable_reg <= interval_count_enable_next;
      flag_reg <= flag_next;
      oneshot_reg <= oneshot_next;
      rsvd6_reg <= rsvd6_next;
      base_reg <= base_next;
    end
  end

  // ****************************************************************
  // timebase prescaler
  // ****************************************************************
  // runs from clk_i, which stays alive in power-down; the core clock
  // may stop but this chain does not
  logic [PW-1:0] pre_reg;
  logic [PW-1:0] pre_next;
  logic sub_tick;

  assign sub_tick = timekeeping_clock_enable_reg && (pre_reg == PRE_LAST);

  always_comb begin
    pre_next = pre_reg;
    if (!timekeeping_clock_enable_reg) begin
      pre_next = PRE_ZERO;
    end else if (pre_reg == PRE_LAST) begin
      pre_next = PRE_ZERO;
    end else begin
      pre_next = pre_reg + PRE_ONE;
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pre_reg <= PRE_ZERO;
    end else begin
      pre_reg <= pre_next;
    end
  end

  // ****************************************************************
  // time-of-day chain
  // ****************************************************************
  count_if tick_c ();
  count_if sec_c ();
  count_if min_c ();
  count_if hour_c ();

  assign tick_c.clear = timekeeping_clock_enable_off;
  assign tick_c.load = time_wr_ok && (sfr_addr_i == TICK_ADDR);
  assign tick_c.load_val = sfr_wdata_i;
  assign tick_c.inc = sub_tick;

  assign sec_c.clear = timekeeping_clock_enable_off;
  assign sec_c.load = time_wr_ok && (sfr_addr_i == SEC_ADDR);
  assign sec_c.load_val = sfr_wdata_i;
  assign sec_c.inc = tick_c.carry;

  assign min_c.clear = timekeeping_clock_enable_off;
  assign min_c.load = time_wr_ok && (sfr_addr_i == MIN_ADDR);
  assign min_c.load_val = sfr_wdata_i;
  assign min_c.inc = sec_c.carry;

  assign hour_c.clear = timekeeping_clock_enable_off;
  assign hour_c.load = time_wr_ok && (sfr_addr_i == HOUR_ADDR);
  assign hour_c.load_val = sfr_wdata_i;
  assign hour_c.inc = min_c.carry;

  wrap_counter #(.MAX_VAL(TICK_MAX)) u_tick (
    .clk_i(clk_i),
    .rst_b_i(rst_sync_b),
    .port_io(tick_c.cnt)
  );

  wrap_counter #(.MAX_VAL(SEC_MAX)) u_sec (
    .clk_i(clk_i),
    .rst_b_i(rst_sync_b),
    .port_io(sec_c.cnt)
  );

  wrap_counter #(.MAX_VAL(MIN_MAX)) u_min (
    .clk_i(clk_i),
    .rst_b_i(rst_sync_b),
    .port_io(min_c.cnt)
  );

  // hours carry goes nowhere; a day simply wraps
  wrap_counter #(.MAX_VAL(HOUR_MAX)) u_hour (
    .clk_i(clk_i),
    .rst_b_i(rst_sync_b),
    .port_io(hour_c.cnt)
  );

  // ****************************************************************
  // interval counter
  // ****************************************************************
  logic [7:0] target_reg;
  logic [7:0] target_next;
  logic [7:0] ivl_reg;
  logic [7:0] ivl_next;
  logic [7:0] ivl_inc;
  logic ivl_tick;
  logic hit;
  logic ivl_run;

  always_comb begin
    case (base_reg)
      BASE_TICK: ivl_tick = sub_tick;
      BASE_SEC: ivl_tick = tick_c.carry;
      BASE_MIN: ivl_tick = sec_c.carry;
      BASE_HOUR: ivl_tick = min_c.carry;
      default: ivl_tick = 1'b0;
    endcase
  end

  // compare the value being counted to, so a match takes exactly
  // target ticks; a target of zero therefore needs 256 ticks
  assign ivl_inc = ivl_reg + COUNT_ONE;
  assign hit = (ivl_inc == target_reg);
  assign ivl_run = interval_count_enable_reg && timekeeping_clock_enable_reg;
  assign timeout = ivl_run && ivl_tick && hit;

  always_comb begin
    target_next = target_wr ? sfr_wdata_i : target_reg;
    ivl_next = ivl_reg;
    if (!ivl_run || timekeeping_clock_enable_off) begin
      ivl_next = REG_RESET;
    end else if (ctrl_wr && !sfr_wdata_i[INTERVAL_COUNT_ENABLE_BIT]) begin
      ivl_next = REG_RESET;
    end else if (ivl_tick) begin
      ivl_next = hit ? REG_RESET : ivl_inc;
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      target_reg <= REG_RESET;
      ivl_reg <= REG_RESET;
    end else begin
      target_reg <= target_next;
      ivl_reg <= ivl_next;
    end
  end

  // ****************************************************************
  // read port and requests
  // ****************************************************************
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] ctrl_view;

  always_comb begin
    ctrl_view = REG_RESET;
    ctrl_view[TIMEKEEPING_CLOCK_ENABLE_BIT] = timekeeping_clock_enable_reg;
    ctrl_view[INTERVAL_COUNT_ENABLE_BIT] = interval_count_enable_reg;
    ctrl_view[FLAG_BIT] = flag_reg;
    ctrl_view[ONESHOT_BIT] = oneshot_reg;
    ctrl_view[BASE_LO_BIT] = base_reg[0];
    ctrl_view[BASE_HI_BIT] = base_reg[1];
    ctrl_view[RSVD6_BIT] = rsvd6_reg;
    ctrl_view[RSVD7_BIT] = 1'b0;
  end

  always_comb begin
    rdata_next = rdata_reg;
    if (sfr_rd_i) begin
      case (sfr_addr_i)
        CTRL_ADDR: rdata_next = ctrl_view;
        TICK_ADDR: rdata_next = tick_c.value;
        SEC_ADDR: rdata_next = sec_c.value;
        MIN_ADDR: rdata_next = min_c.value;
        HOUR_ADDR: rdata_next = hour_c.value;
        TARGET_ADDR: rdata_next = target_reg;
        default: rdata_next = REG_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rdata_reg <= REG_RESET;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign sfr_rdata_o = rdata_reg;
  assign irq_o = flag_reg && irq_enable_i;
  assign wake_o = irq_o && power_down_i;
  assign wake_vector_o = WAKE_VECTOR;

  // ****************************************************************
  // checks
  // ****************************************************************
  base_select_a: assert property (@(posedge clk_i) disable iff (!rst_sync_b)
    base_reg == BASE_SEC |-> ivl_tick == (sub_tick && tick_c.value == TICK_MAX))
    else $error("seconds base does not follow the tick carry");

  one_shot_a: assert property (@(posedge clk_i) disable iff (!rst_sync_b)
    timeout && oneshot_reg && !ctrl_wr |=> !interval_count_enable_reg && ivl_reg == REG_RESET)
    else $error("one-shot timeout left counting enabled");

  repeat_reload_a: assert property (@(posedge clk_i) disable iff (!rst_sync_b)
    timeout && !oneshot_reg && !ctrl_wr |=> interval_count_enable_reg && ivl_reg == REG_RESET)
    else $error("repeating timeout did not reload");

  flag_sticky_a: assert property (@(posedge clk_i) disable iff (!rst_sync_b)
    timeout |=> flag_reg ##1 (flag_reg || $past(ctrl_wr)))
    else $error("match flag missed or dropped by itself");

  flag_cause_a: assert property (@(posedge clk_i) disable iff (!rst_sync_b)
    $rose(flag_reg) |-> $past(timeout))
    else $error("match flag set without a match");

  irq_follow_a: assert property (@(posedge clk_i) disable iff (!rst_sync_b)
    irq_o == (flag_reg && irq_enable_i))
    else $error("interrupt request disagrees with flag and enable");

  count_step_a: assert property (@(posedge clk_i) disable iff (!rst_sync_b)
    ivl_run && ivl_tick && !hit && !ctrl_wr |=> ivl_reg == $past(ivl_reg) + COUNT_ONE)
    else $error("interval counter did not advance");

  count_hold_a: assert property (@(posedge clk_i) disable iff (!rst_sync_b)
    ivl_run && !ivl_tick && !ctrl_wr |=> $stable(ivl_reg))
    else $error("interval counter moved without a tick");

  stop_clear_a: assert property (@(posedge clk_i) disable iff (!rst_sync_b)
    ctrl_wr && !sfr_wdata_i[INTERVAL_COUNT_ENABLE_BIT] |=> ivl_reg == REG_RESET [*2])
    else $error("disabled interval counter not cleared");

  gate_off_a: assert property (@(posedge clk_i) disable iff (!rst_sync_b)
    !timekeeping_clock_enable_reg |-> !sub_tick && !ivl_tick)
    else $error("timebase ticks while timekeeping is off");

  time_clear_a: assert property (@(posedge clk_i) disable iff (!rst_sync_b)
    timekeeping_clock_enable_off |=> tick_c.value == REG_RESET && sec_c.value == REG_RESET
      && min_c.value == REG_RESET && hour_c.value == REG_RESET && ivl_reg == REG_RESET)
    else $error("time registers not cleared on disable");

  time_load_a: assert property (@(posedge clk_i) disable iff (!rst_sync_b)
    sfr_wr_i && sfr_addr_i == HOUR_ADDR && !timekeeping_clock_enable_reg |=> hour_c.value == $past(sfr_wdata_i))
    else $error("hours load refused while stopped");

  time_lock_a: assert property (@(posedge clk_i) disable iff (!rst_sync_b)
    sfr_wr_i && sfr_addr_i == SEC_ADDR && timekeeping_clock_enable_reg && !tick_c.carry |=> $stable(sec_c.value))
    else $error("seconds changed by a write while running");

  wake_a: assert property (@(posedge clk_i) disable iff (!rst_sync_b)
    flag_reg && irq_enable_i && power_down_i |-> wake_o && wake_vector_o == WAKE_VECTOR)
    else $error("powered-down core not woken");

  rsvd_read_a: assert property (@(posedge clk_i) disable iff (!rst_sync_b)
    sfr_rd_i && sfr_addr_i == CTRL_ADDR |=> !sfr_rdata_o[RSVD7_BIT])
    else $error("reserved bit 7 reads nonzero");

  one_shot_c: cover property (@(posedge clk_i) disable iff (!rst_sync_b)
    timeout && oneshot_reg);

  repeat_c: cover property (@(posedge clk_i) disable iff (!rst_sync_b)
    timeout && !oneshot_reg ##[1:600] timeout);

  time_off_c: cover property (@(posedge clk_i) disable iff (!rst_sync_b)
    timekeeping_clock_enable_off);

  wake_c: cover property (@(posedge clk_i) disable iff (!rst_sync_b)
    wake_o);
endmodule

/* File: hw/wrap_counter.sv */
`timescale 1ns/10ps
module wrap_counter #(
  parameter logic [7:0] MAX_VAL = 8'h3b
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  count_if.cnt port_io
);
  import tic_pkg::*;

  logic [7:0] value_reg;
  logic [7:0] value_next;
  logic at_top;

  // ****************************************************************
  // wrapping count
  // ****************************************************************
  // values loaded above the top also wrap, so a bad load self-heals
  assign at_top = (value_reg >= MAX_VAL);
  assign port_io.carry = port_io.inc && at_top;
  assign port_io.value = value_reg;

  always_comb begin
    value_next = value_reg;
    if (port_io.clear) begin
      value_next = REG_RESET;
    end else if (port_io.load) begin
      value_next = port_io.load_val;
    end else if (port_io.inc) begin
      value_next = at_top ? REG_RESET : value_reg + COUNT_ONE;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      value_reg <= REG_RESET;
    end else begin
      value_reg <= value_next;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  count_wrap_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    port_io.inc && value_reg == MAX_VAL && !port_io.clear && !port_io.load
    |=> value_reg == REG_RESET)
    else $error("counter did not wrap at its top value");

  count_step_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    port_io.inc && value_reg < MAX_VAL && !port_io.clear && !port_io.load
    |=> value_reg == $past(value_reg) + COUNT_ONE)
    else $error("counter did not step by one");

  count_carry_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    port_io.carry |-> port_io.inc && value_reg == MAX_VAL)
    else $error("carry raised away from the top value");

  count_wrap_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    port_io.carry);
endmodule

/* File: pkg/count_if.sv */
`timescale 1ns/10ps
interface count_if;
  logic clear;
  logic load;
  logic inc;
  logic [7:0] load_val;
  logic [7:0] value;
  logic carry;

  modport ctrl (
    output clear,
    output load,
    output inc,
    output load_val,
    input value,
    input carry
  );

  modport cnt (
    input clear,
    input load,
    input inc,
    input load_val,
    output value,
    output carry
  );
endinterface

/* File: pkg/tic_pkg.sv */
package tic_pkg;

  // ****************************************************************
  // register addresses
  // ****************************************************************
  localparam logic [7:0] CTRL_ADDR = 8'ha1;
  localparam logic [7:0] TICK_ADDR = 8'ha2;
  localparam logic [7:0] SEC_ADDR = 8'ha3;
  localparam logic [7:0] MIN_ADDR = 8'ha4;
  localparam logic [7:0] HOUR_ADDR = 8'ha5;
  localparam logic [7:0] TARGET_ADDR = 8'ha6;

  // ****************************************************************
  // interval control fields
  // ****************************************************************
  localparam int TIMEKEEPING_CLOCK_ENABLE_BIT = 0;
  localparam int INTERVAL_COUNT_ENABLE_BIT = 1;
  localparam int FLAG_BIT = 2;
  localparam int ONESHOT_BIT = 3;
  localparam int BASE_LO_BIT = 4;
  localparam int BASE_HI_BIT = 5;
  localparam int RSVD6_BIT = 6;
  localparam int RSVD7_BIT = 7;

  typedef enum logic [1:0] {
    BASE_TICK = 2'h0,
    BASE_SEC = 2'h1,
    BASE_MIN = 2'h2,
    BASE_HOUR = 2'h3
  } base_sel_t;

  // ****************************************************************
  // counter limits and reset values
  // ****************************************************************
  localparam logic [7:0] TICK_MAX = 8'h7f;
  localparam logic [7:0] SEC_MAX = 8'h3b;
  localparam logic [7:0] MIN_MAX = 8'h3b;
  localparam logic [7:0] HOUR_MAX = 8'h17;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic [15:0] WAKE_VECTOR = 16'h0053;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_PERIOD_NS = 7812500;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

endpackage

/* File: verif/test_time_interval_counter.sv */
`timescale 1ns/10ps
module test_time_interval_counter;
  import tic_pkg::*;

  // ****************************************************************
  // signals and design under test
  // ****************************************************************
  // short prescale so a full carry chain fits in a few dozen cycles
  localparam int TDIV = 4;
  logic clk_i;
  logic rst_b_i;
  logic [7:0] sfr_addr_i;
  logic sfr_wr_i;
  logic [7:0] sfr_wdata_i;
  logic sfr_rd_i;
  logic [7:0] sfr_rdata_o;
  logic irq_enable_i;
  logic power_down_i;
  logic irq_o;
  logic wake_o;
  logic [15:0] wake_vector_o;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int t1;
  int n0;
  int nb;
  logic [31:0] tk_pre [3] = '{32'h7f3b3b17, 32'h7f3b0516, 32'h7f053b17};
  logic [23:0] tk_exp [3] = '{24'h000000, 24'h000616, 24'h063b17};

  time_interval_counter #(.TICK_DIV(TDIV)) uut (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i),
    .sfr_wdata_i(sfr_wdata_i),
    .sfr_rd_i(sfr_rd_i),
    .sfr_rdata_o(sfr_rdata_o),
    .irq_enable_i(irq_enable_i),
    .power_down_i(power_down_i),
    .irq_o(irq_o),
    .wake_o(wake_o),
    .wake_vector_o(wake_vector_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
  end

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_i);
    #1;
    sfr_wr_i = 1'b1;
    sfr_addr_i = addr;
    sfr_wdata_i = data;
    @(posedge clk_i);
    #1;
    sfr_wr_i = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp, input string msg);
    @(posedge clk_i);
    #1;
    sfr_rd_i = 1'b1;
    sfr_addr_i = addr;
    @(posedge clk_i);
    #1;
    sfr_rd_i = 1'b0;
    // data is registered; one more edge costs nothing since it holds
    @(posedge clk_i);
    #1;
    chk({8'h00, sfr_rdata_o}, {8'h00, exp}, msg);
  endtask

  task automatic wait_irq(output int n);
    n = 0;
    while (irq_o !== 1'b1 && n < 600) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk(16'(n < 600), 16'h1, "interrupt never came");
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    finish_test();
  end

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    rst_b_i = 1'b0;
    sfr_addr_i = 8'h00;
    sfr_wr_i = 1'b0;
    sfr_wdata_i = 8'h00;
    sfr_rd_i = 1'b0;
    irq_enable_i = 1'b1;
    power_down_i = 1'b0;
    repeat (8) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    repeat (3) @(posedge clk_i);

    // reset values, unmapped address, fixed vector
    for (int a = 8'ha0; a <= 8'ha6; a++) begin
      rd_chk(8'(a), 8'h00, "reset value");
    end
    chk(wake_vector_o, 16'h0053, "wake vector");
    chk({15'h0, irq_o}, 16'h0, "irq after reset");
    wr(CTRL_ADDR, 8'hc0);
    rd_chk(CTRL_ADDR, 8'h40, "reserved bits");

    // loads while stopped, then carry chain on the first wrap
    for (int i = 0; i < 3; i++) begin
      wr(CTRL_ADDR, 8'h40);
      wr(TICK_ADDR, tk_pre[i][31:24]);
      wr(SEC_ADDR, tk_pre[i][23:16]);
      wr(MIN_ADDR, tk_pre[i][15:8]);
      wr(HOUR_ADDR, tk_pre[i][7:0]);
      wr(CTRL_ADDR, 8'h41);
      repeat (TDIV + 3) @(posedge clk_i);
      rd_chk(SEC_ADDR, tk_exp[i][23:16], "seconds after wrap");
      rd_chk(MIN_ADDR, tk_exp[i][15:8], "minutes after wrap");
      rd_chk(HOUR_ADDR, tk_exp[i][7:0], "hours after wrap");
    end
    wr(SEC_ADDR, 8'h20);
    rd_chk(SEC_ADDR, 8'h06, "write while running");
    wr(CTRL_ADDR, 8'h40);
    repeat (3 * TDIV) @(posedge clk_i);
    for (int a = 8'ha2; a <= 8'ha5; a++) begin
      rd_chk(8'(a), 8'h00, "cleared on stop");
    end

    // every interval base: one step in two ticks' time, or in one for ticks
    for (int b = 0; b < 4; b++) begin
      wr(CTRL_ADDR, 8'h40);
      wr(TICK_ADDR, 8'h7e);
      wr(SEC_ADDR, (b >= 2) ? 8'h3b : 8'h00);
      wr(MIN_ADDR, (b == 3) ? 8'h3b : 8'h00);
      wr(TARGET_ADDR, 8'h01);
      wr(CTRL_ADDR, {2'h1, 2'(b), 4'h3});
      wait_irq(nb);
      if (b == 0) begin
        n0 = nb;
        chk(16'(n0 >= TDIV - 1 && n0 <= TDIV + 3), 16'h1, "tick base latency");
      end else begin
        chk(16'(nb), 16'(n0 + TDIV), "base latency");
      end
    end

    // repeating mode: spacing between matches is exactly target ticks
    wr(CTRL_ADDR, 8'h40);
    wr(TARGET_ADDR, 8'h03);
    wr(CTRL_ADDR, 8'h43);
    wait_irq(nb);
    t1 = cyc;
    chk(16'(nb), 16'(n0 + 2 * TDIV), "first match latency");
    rd_chk(CTRL_ADDR, 8'h47, "flag set, still enabled");
    wr(CTRL_ADDR, 8'h43);
    chk({15'h0, irq_o}, 16'h0, "flag cleared by write");
    wait_irq(nb);
    chk(16'(cyc - t1), 16'(3 * TDIV), "repeat spacing");

    // stopping the interval counter zeroes it
    wr(CTRL_ADDR, 8'h43);
    // prescaler keeps running; re-enable lands on a tick edge, as before
    repeat (TDIV + 2) @(posedge clk_i);
    wr(CTRL_ADDR, 8'h41);
    wr(CTRL_ADDR, 8'h43);
    wait_irq(nb);
    chk(16'(nb), 16'(n0 + 2 * TDIV), "count restarts at zero");

    // one-shot: enable drops at timeout, flag drives irq and wake
    wr(CTRL_ADDR, 8'h41);
    wr(CTRL_ADDR, 8'h4b);
    wait_irq(nb);
    chk(16'(nb), 16'(n0 + 2 * TDIV), "one-shot latency");
    rd_chk(CTRL_ADDR, 8'h4d, "one-shot clears enable");
    irq_enable_i = 1'b0;
    #1;
    chk({15'h0, irq_o}, 16'h0, "irq masked");
    @(posedge clk_i);
    #1;
    irq_enable_i = 1'b1;
    power_down_i = 1'b1;
    #1;
    chk({15'h0, irq_o}, 16'h1, "irq unmasked");
    chk({15'h0, wake_o}, 16'h1, "wake in power-down");
    @(posedge clk_i);
    #1;
    power_down_i = 1'b0;
    #1;
    chk({15'h0, wake_o}, 16'h0, "no wake when running");
    wr(CTRL_ADDR, 8'h49);
    repeat (5 * TDIV) @(posedge clk_i);
    chk({15'h0, irq_o}, 16'h0, "no timeout after one-shot");
    rd_chk(CTRL_ADDR, 8'h49, "control after one-shot");
    finish_test();
  end
endmodule
